// ===== host_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// host memory holding rings and lists
// ----------------------------------------
module host_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pacing
  input wire logic slow,
  // memory port
  input wire logic req_valid,
  output wire logic req_ready,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_wdata,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata
);
  logic [31:0] mem [0:511];
  logic pend;
  logic tick;
  logic [1:0] cnt;
  logic [8:0] ad;
  // one read in flight, slow mode takes every other cycle
  assign req_ready = !pend && (!slow || tick);
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      {pend, tick, cnt, ad, rsp_valid} <= '0;
      rsp_rdata <= 32'h0;
    end else begin
      tick <= ~tick;
      rsp_valid <= 1'b0;
      rsp_rdata <= ~rsp_rdata; // stale data never holds
      if (pend && cnt == 2'h0) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= mem[ad];
        pend <= 1'b0;
      end else if (pend) begin
        cnt <= cnt - 2'h1;
      end
      if (req_valid && req_ready && req_write) begin
        mem[req_addr[10:2]] <= req_wdata;
      end else if (req_valid && req_ready) begin
        pend <= 1'b1;
        cnt <= slow ? 2'h3 : 2'h0;
        ad <= req_addr[10:2];
      end
    end
  end
endmodule : host_mem_model

// ===== qp_pkg.sv
package qp_pkg;

  // ----------------------------------------------------------------
  // ring geometry
  // ----------------------------------------------------------------
  localparam int NUM_SQ = 2;
  localparam int RINGS = NUM_SQ + 1;
  localparam int CQ_IDX = NUM_SQ;
  localparam int IDX_W = 3;
  localparam logic [IDX_W-1:0] LAST_SLOT = 3'h7;
  localparam int CMD_BYTES = 64;
  localparam int CMD_WORDS = CMD_BYTES / 4;
  localparam logic [3:0] CMD_LAST_WORD = 4'hf;
  localparam logic [3:0] CPL_LAST_WORD = 4'h3;
  localparam logic [3:0] PRP_LAST_WORD = 4'h1;
  localparam logic [3:0] SGL_LAST_WORD = 4'h3;
  localparam logic [7:0] PRP_LIST_MAX = 8'h10;
  localparam logic [0:0] ADMIN_ID = 1'h0;
  localparam logic [7:0] FUNC_NUM = 8'h00;

  // ----------------------------------------------------------------
  // command word layout
  // ----------------------------------------------------------------
  localparam int PTR1_WORD = 6;
  localparam int PTR2_WORD = 8;
  localparam int CID_LO = 16;
  localparam int DESC_SEL_HI = 15;
  localparam int DESC_SEL_LO = 14;
  localparam int LIST_BIT = 13;
  localparam int SGL_TYPE_LO = 28;
  localparam logic [3:0] SGL_TYPE_DATA = 4'h0;
  localparam logic [3:0] SGL_TYPE_SEG = 4'h2;
  localparam logic [3:0] SGL_TYPE_LAST = 4'h3;
  localparam int CPL_PHASE_BIT = 16;

  // ----------------------------------------------------------------
  // register map (byte offsets) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] CQ_BASE_OFF = 8'h08;
  localparam logic [7:0] CQ_HEAD_OFF = 8'h0c;
  localparam logic [7:0] SQ_BASE_OFF = 8'h10;
  localparam logic [7:0] SQ_TAIL_OFF = 8'h14;
  localparam logic [7:0] SQ_STRIDE = 8'h08;
  localparam logic [7:0] PTRS_OFF = 8'h20;
  localparam logic [7:0] IDENT_OFF = 8'h24;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;

  typedef enum logic [8:0] {
    st_idle = 9'h001,
    st_fetch = 9'h002,
    st_fetch_wait = 9'h004,
    st_eval = 9'h008,
    st_emit = 9'h010,
    st_ent_rd = 9'h020,
    st_ent_wait = 9'h040,
    st_issue = 9'h080,
    st_cpl_wr = 9'h100
  } engine_state_t;

endpackage : qp_pkg

// ===== queue_pair_command_engine_tb.sv
`timescale 1ns/1ps
module queue_pair_command_engine_tb;
  import qp_pkg::*;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, slow = 0, g, se;
  logic [7:0] paddr = 8'h00, c_op, fnum;
  logic [31:0] pwdata = 32'h0, prdata, rd, maddr, mwdata, mrdata, d_addr, d_len;
  logic pready, pslverr, mreq_v, mreq_r, mreq_w, mrsp_v, desc_v, cmd_v, cpl_r, c_admin;
  logic desc_r = 0, cmd_r = 1, cpl_v = 0;
  logic [0:0] c_ring, cpl_ring = 1'h0;
  logic [15:0] c_id, cpl_id = 16'h0;
  logic [14:0] cpl_st = 15'h0;
  logic [63:0] seen [$];
  int failures = 0, n_tests = 0;
  // ----------------------------------------
  // clock, executor log
  // ----------------------------------------
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    desc_r <= ~desc_r;
    if (desc_v && desc_r) seen.push_back({d_addr, d_len});
    if (cmd_v && cmd_r) seen.push_back({16'hffff, 15'h0, c_admin, 15'h0, c_ring, c_id});
  end
  queue_pair_engine dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req_valid(mreq_v), .mem_req_ready(mreq_r), .mem_req_write(mreq_w),
    .mem_req_addr(maddr), .mem_req_wdata(mwdata), .mem_rsp_valid(mrsp_v),
    .mem_rsp_rdata(mrdata), .desc_valid(desc_v), .desc_ready(desc_r), .desc_addr(d_addr),
    .desc_len(d_len), .cmd_valid(cmd_v), .cmd_ready(cmd_r), .cmd_ring(c_ring),
    .cmd_admin(c_admin), .cmd_id(c_id), .cmd_opcode(c_op), .cpl_valid(cpl_v),
    .cpl_ready(cpl_r), .cpl_ring(cpl_ring), .cpl_id(cpl_id), .cpl_status(cpl_st),
    .shared_ns_handle(32'h5a5a_0002), .function_number(fnum));
  host_mem_model host_u (.clk(clk), .reset(reset), .slow(slow), .req_valid(mreq_v),
    .req_ready(mreq_r), .req_write(mreq_w), .req_addr(maddr), .req_wdata(mwdata),
    .rsp_valid(mrsp_v), .rsp_rdata(mrdata));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      failures++;
      finish_test();
    end
    rd = prdata;
    se = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task ev(input string nm, input logic [63:0] e);
    for (int i = 0; i < 400 && seen.size() == 0; i++) @(negedge clk);
    if (seen.size() == 0) begin
      failures++;
      finish_test();
    end
    chk(nm, e, seen.pop_front());
  endtask : ev
  task put(input int base, input int slot, input logic [31:0] w0, w6, w8, w9);
    int b;
    b = base / 4 + slot * 16;
    for (int k = 0; k < 16; k++) host_u.mem[b + k] = 32'h0;
    {host_u.mem[b], host_u.mem[b + 6], host_u.mem[b + 8], host_u.mem[b + 9]} = {w0, w6, w8, w9};
  endtask : put
  task cpl(input logic r, input logic [15:0] id, input logic [14:0] st, input int lim);
    @(posedge clk);
    {cpl_v, cpl_ring, cpl_id, cpl_st} <= {1'b1, r, id, st};
    g = 0;
    for (int i = 0; i < lim && !g; i++) begin
      @(posedge clk);
      g = (cpl_r === 1'b1);
    end
    if (g) begin
      cpl_v <= 1'b0;
    end else if (lim == 400) begin
      failures++;
      finish_test();
    end
  endtask : cpl
  function automatic logic [63:0] ce(input logic r, input logic [15:0] id);
    return {16'hffff, 15'h0, ~r, 15'h0, r, id};
  endfunction : ce
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    chk("func", 8'h00, fnum);
    apb(0, STATUS_OFF, 0);
    chk("status", 32'h2c, rd);
    apb(0, IDENT_OFF, 0);
    chk("ident", 32'h5a5a_0002, rd);
    apb(0, 8'h28, 32'h1);
    chk("unmapped", 33'h1_0000_0000, {se, rd});
    apb(0, SQ_BASE_OFF, 0);
    chk("base", BASE_RESET, rd);
    apb(1, CQ_BASE_OFF, 32'h400);
    apb(1, SQ_BASE_OFF + SQ_STRIDE, 32'h200);
    put(0, 0, 32'h0022_4006, 32'h3000, 32'h40, 0);
    put(32'h200, 0, 32'h0011_0002, 32'h1000, 32'h2000, 0);
    apb(1, SQ_TAIL_OFF + SQ_STRIDE, 32'h5);
    apb(1, SQ_TAIL_OFF + SQ_STRIDE, 32'h1);
    apb(1, SQ_TAIL_OFF, 32'h1);
    apb(0, PTRS_OFF, 0);
    chk("ptrs", 32'h1010, rd);
    apb(1, CTRL_OFF, 32'h1);
    ev("sgl", {32'h3000, 32'h40});
    ev("admin", ce(0, 16'h22));
    chk("opcode", 8'h06, c_op);
    ev("prp1", {32'h1000, 32'h0});
    ev("prp2", {32'h2000, 32'h0});
    ev("io", ce(1, 16'h11));
    repeat (100) @(negedge clk);
    chk("beyond tail", 0, seen.size());
    cpl(1, 16'h11, 15'h5, 400);
    cpl(0, 16'h22, 15'h0, 400);
    @(negedge clk);
    chk("cq0 w2", 32'h0001_0001, host_u.mem[258]);
    chk("cq0 w3", 32'h000b_0011, host_u.mem[259]);
    chk("cq1 w3", 32'h0001_0022, host_u.mem[263]);
    slow <= 1'b1;
    host_u.mem[384:389] = '{32'h1200, 0, 32'h1300, 0, 0, 0};
    host_u.mem[448:455] = '{32'h1400, 0, 32'h200, 0, 32'h1500, 0, 32'h100, 0};
    put(32'h200, 1, 32'h0033_2002, 32'h1100, 32'h600, 0);
    put(32'h200, 2, 32'h0044_4002, 32'h700, 32'h20, 32'h3000_0000);
    apb(1, SQ_TAIL_OFF + SQ_STRIDE, 32'h3);
    ev("list a", {32'h1100, 32'h0});
    ev("list b", {32'h1200, 32'h0});
    ev("list c", {32'h1300, 32'h0});
    ev("cmd 33", ce(1, 16'h33));
    ev("seg a", {32'h1400, 32'h200});
    ev("seg b", {32'h1500, 32'h100});
    ev("cmd 44", ce(1, 16'h44));
    cpl(1, 16'h44, 15'h0, 400);
    cpl(1, 16'h33, 15'h0, 400);
    slow <= 1'b0;
    for (int i = 0; i < 7; i++) put(32'h200, (3 + i) % 8, 32'h0050_0002 + (i << 16), 32'h1600, 0, 0);
    apb(1, SQ_TAIL_OFF + SQ_STRIDE, 32'h2);
    for (int i = 0; i < 7; i++) begin
      ev("wrap desc", {32'h1600, 32'h0});
      ev("wrap cmd", ce(1, 16'h50 + i));
    end
    for (int i = 0; i < 3; i++) cpl(1, 16'h50 + i, 15'h0, 400);
    cpl(1, 16'h53, 15'h0, 40);
    chk("cq full", 0, g);
    apb(1, CQ_HEAD_OFF, 32'h4);
    cpl(1, 16'h53, 15'h0, 400);
    for (int i = 4; i < 7; i++) cpl(1, 16'h50 + i, 15'h0, 400);
    @(negedge clk);
    chk("cq7 w3", 32'h0001_0053, host_u.mem[287]);
    chk("cq0 w2", 32'h0001_0002, host_u.mem[258]);
    chk("cq0 w3", 32'h0000_0054, host_u.mem[259]);
    apb(0, STATUS_OFF, 0);
    chk("status end", 32'h1e, rd);
    finish_test();
  end
endmodule : queue_pair_command_engine_tb

// ===== queue_pair_engine.sv
`timescale 1ns/1ps
// Summary of operation
// RL1 - host fills submission ring, rings tail doorbell
// RL2 - tail doorbell write replaces held tail
// RL3 - fetch in ring order, execute any order
// RL4 - one 64 byte command per slot
// RL5 - buffer: two page pointers or one segment
// RL6 - follow page pointer list when needed
// RL7 - walk chained scatter gather segments
// RL8 - post completion with ring and command id
// RL9 - all submission rings share one completion ring
// RL10 - host advances completion head after consuming
// RL11 - phase marker inverts each completion pass
// RL12 - sole controller is function zero
// RL13 - same namespace handle across controllers
// RL14 - same namespace identity data everywhere
// RL15 - atomic at own write atomicity level
// RL16 - port reset touches only this controller
// RL17 - identifier zero is the admin pair
// RL18 - other rings use identifiers one upward
// RL19 - submitted only once tail passes slot
// RL20 - wrap indices, never overrun unfreed slots
// RL21 - never fetch beyond tail, equal is empty
module queue_pair_engine (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output wire logic pready,
  output wire logic pslverr,
  // host memory port
  output wire logic mem_req_valid,
  input wire logic mem_req_ready,
  output wire logic mem_req_write,
  output wire logic [31:0] mem_req_addr,
  output wire logic [31:0] mem_req_wdata,
  input wire logic mem_rsp_valid,
  input wire logic [31:0] mem_rsp_rdata,
  // descriptors to the executor
  output wire logic desc_valid,
  input wire logic desc_ready,
  output logic [31:0] desc_addr,
  output logic [31:0] desc_len,
  // commands to the executor
  output wire logic cmd_valid,
  input wire logic cmd_ready,
  output logic [0:0] cmd_ring,
  output logic cmd_admin,
  output logic [15:0] cmd_id,
  output logic [7:0] cmd_opcode,
  // completions from the executor
  input wire logic cpl_valid,
  output wire logic cpl_ready,
  input wire logic [0:0] cpl_ring,
  input wire logic [15:0] cpl_id,
  input wire logic [14:0] cpl_status,
  // subsystem identity
  input wire logic [31:0] shared_ns_handle,
  output wire logic [7:0] function_number
);
  import qp_pkg::*;

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  engine_state_t state_reg, state_next;
  logic enable_reg;
  logic [31:0] sq_base_reg [NUM_SQ];
  logic [31:0] cq_base_reg;
  logic [31:0] cmd_words_reg [CMD_WORDS];
  logic [31:0] ent_reg [4];
  logic [31:0] ent_addr_reg;
  logic [7:0] ent_left_reg;
  logic [3:0] word_reg;
  logic [0:0] sel_reg;
  logic sgl_reg, inline_reg, second_reg;
  logic [IDX_W-1:0] host_ptr [RINGS];
  logic [IDX_W-1:0] dev_ptr [RINGS];
  logic [RINGS-1:0] empty, full, phase, host_load, dev_adv;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite;
  wire hit_ctrl = (paddr == CTRL_OFF);
  wire hit_status = (paddr == STATUS_OFF);
  wire hit_cq_base = (paddr == CQ_BASE_OFF);
  wire hit_cq_head = (paddr == CQ_HEAD_OFF);
  wire hit_ptrs = (paddr == PTRS_OFF);
  wire hit_ident = (paddr == IDENT_OFF);
  wire [NUM_SQ-1:0] hit_sq_base, hit_sq_tail;
  wire hit_any = hit_ctrl | hit_status | hit_cq_base | hit_cq_head | hit_ptrs | hit_ident
                 | (|hit_sq_base) | (|hit_sq_tail);
  wire [31:0] status_word = {26'h0, phase[CQ_IDX], full[CQ_IDX], empty[NUM_SQ-1:0],
                             enable_reg, (state_reg != st_idle)};
  wire [31:0] ptrs_word = {8'h0, 1'b0, host_ptr[CQ_IDX], 1'b0, dev_ptr[CQ_IDX],
                           1'b0, host_ptr[1], 1'b0, dev_ptr[1], 1'b0, host_ptr[0], 1'b0, dev_ptr[0]};
  logic [31:0] read_mux;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  // RL12 single function device
  assign function_number = FUNC_NUM;

  // rings: per-ring doorbell and one shared completion ring
  genvar g;
  generate
    for (g = 0; g < RINGS; g++) begin : g_ring
      if (g < NUM_SQ) begin : g_sq
        assign hit_sq_base[g] = (paddr == SQ_BASE_OFF + SQ_STRIDE * 8'(g));
        assign hit_sq_tail[g] = (paddr == SQ_TAIL_OFF + SQ_STRIDE * 8'(g));
        // RL19 tail write makes commands submitted
        assign host_load[g] = apb_wr & hit_sq_tail[g];
        // RL3 head steps one slot per fetch
        assign dev_adv[g] = (state_reg == st_fetch_wait) & mem_rsp_valid
                            & (word_reg == CMD_LAST_WORD) & (sel_reg == 1'(g));
      end else begin : g_cq
        // RL10 host frees completion slots
        assign host_load[g] = apb_wr & hit_cq_head;
        assign dev_adv[g] = cpl_ready;
      end
      ring_pointer u_ring (
        .clk(clk),
        .reset(reset),
        .host_load(host_load[g]),
        .host_value(pwdata[IDX_W-1:0]),
        .dev_advance(dev_adv[g]),
        .host_ptr(host_ptr[g]),
        .dev_ptr(dev_ptr[g]),
        .empty(empty[g]),
        .full(full[g]),
        .phase(phase[g])
      );
    end
  endgenerate

  // read data selection, unmapped reads as zero
  always_comb begin
    read_mux = 32'h0;
    if (hit_ctrl) read_mux = {31'h0, enable_reg};
    if (hit_status) read_mux = status_word;
    if (hit_cq_base) read_mux = cq_base_reg;
    if (hit_cq_head) read_mux = {29'h0, host_ptr[CQ_IDX]};
    if (hit_ptrs) read_mux = ptrs_word;
    // RL13 RL14 handle and identity shared
    if (hit_ident) read_mux = shared_ns_handle;
    for (int i = 0; i < NUM_SQ; i++) begin
      if (hit_sq_base[i]) read_mux = sq_base_reg[i];
      if (hit_sq_tail[i]) read_mux = {29'h0, host_ptr[i]};
    end
  end

  // register writes and registered read data
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enable_reg <= 1'b0;
      cq_base_reg <= BASE_RESET;
      sq_base_reg <= '{default: BASE_RESET};
      prdata <= 32'h0;
    end else begin
      if (apb_setup) prdata <= read_mux;
      if (apb_wr && hit_ctrl) enable_reg <= pwdata[CTRL_EN_BIT];
      if (apb_wr && hit_cq_base) cq_base_reg <= pwdata;
      for (int i = 0; i < NUM_SQ; i++) begin
        if (apb_wr && hit_sq_base[i]) sq_base_reg[i] <= pwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // descriptor evaluation
  // ----------------------------------------------------------------
  wire [31:0] dw0 = cmd_words_reg[0];
  wire [3:0] ent_type = ent_reg[3][SGL_TYPE_LO+3:SGL_TYPE_LO];
  wire [7:0] seg_count = ent_reg[2][11:4];
  wire ent_zero = (ent_reg[0] == 32'h0);
  // RL5 page pointer or inline segment
  wire eval_emit = sgl_reg ? (ent_type == SGL_TYPE_DATA) : ~ent_zero;
  // RL7 segment pointer continues chain
  wire eval_chain = sgl_reg & ((ent_type == SGL_TYPE_SEG) | (ent_type == SGL_TYPE_LAST));
  wire want_second = inline_reg & ~sgl_reg & ~second_reg;
  // RL6 second pointer names a list
  wire second_list = dw0[LIST_BIT];
  wire list_more = (ent_left_reg != 8'h0) & ~(~sgl_reg & ~inline_reg & ent_zero);
  wire step = ((state_reg == st_emit) & desc_ready)
              | ((state_reg == st_eval) & ~eval_emit & ~eval_chain);
  wire [3:0] ent_last = sgl_reg ? SGL_LAST_WORD : PRP_LAST_WORD;
  wire fetch_done = (state_reg == st_fetch_wait) & mem_rsp_valid & (word_reg == CMD_LAST_WORD);
  wire ent_done = (state_reg == st_ent_wait) & mem_rsp_valid & (word_reg == ent_last);
  wire [0:0] pick = empty[0] ? 1'h1 : 1'h0;

  // ----------------------------------------------------------------
  // host memory requests and executor handshakes
  // ----------------------------------------------------------------
  wire [31:0] fetch_addr = sq_base_reg[sel_reg] + {23'h0, dev_ptr[sel_reg], 6'h0}
                           + {26'h0, word_reg, 2'h0};
  wire [31:0] cpl_addr = cq_base_reg + {25'h0, dev_ptr[CQ_IDX], 4'h0} + {26'h0, word_reg, 2'h0};
  logic [31:0] cpl_word;

  // RL8 entry carries ring and command id
  always_comb begin
    case (word_reg[1:0])
      2'h2: cpl_word = {15'h0, cpl_ring, 13'h0, dev_ptr[cpl_ring]};
      2'h3: cpl_word = {cpl_status, phase[CQ_IDX], cpl_id};
      default: cpl_word = 32'h0;
    endcase
  end

  assign mem_req_valid = (state_reg == st_fetch) | (state_reg == st_ent_rd)
                         | (state_reg == st_cpl_wr);
  assign mem_req_write = (state_reg == st_cpl_wr);
  assign mem_req_addr = (state_reg == st_fetch) ? fetch_addr
                      : (state_reg == st_ent_rd) ? ent_addr_reg : cpl_addr;
  assign mem_req_wdata = cpl_word;
  assign desc_valid = (state_reg == st_emit);
  assign cmd_valid = (state_reg == st_issue);
  // phase word goes last so the host never sees a half entry
  assign cpl_ready = (state_reg == st_cpl_wr) & mem_req_ready & (word_reg == CPL_LAST_WORD);

  // ----------------------------------------------------------------
  // engine sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_idle: begin
        // RL9 completions from any ring, RL20 only into freed slots
        if (enable_reg && cpl_valid && !full[CQ_IDX]) state_next = st_cpl_wr;
        // RL21 fetch only below the tail
        else if (enable_reg && !(&empty[NUM_SQ-1:0])) state_next = st_fetch;
      end
      st_fetch: if (mem_req_ready) state_next = st_fetch_wait;
      st_fetch_wait: begin
        if (fetch_done) state_next = st_eval;
        else if (mem_rsp_valid) state_next = st_fetch;
      end
      st_eval: begin
        if (eval_emit) state_next = st_emit;
        else if (eval_chain) state_next = (seg_count != 8'h0) ? st_ent_rd : st_issue;
        else if (want_second) state_next = second_list ? st_ent_rd : st_eval;
        else state_next = list_more ? st_ent_rd : st_issue;
      end
      st_emit: begin
        if (desc_ready && want_second) state_next = second_list ? st_ent_rd : st_eval;
        else if (desc_ready) state_next = list_more ? st_ent_rd : st_issue;
      end
      st_ent_rd: if (mem_req_ready) state_next = st_ent_wait;
      st_ent_wait: begin
        if (ent_done) state_next = st_eval;
        else if (mem_rsp_valid) state_next = st_ent_rd;
      end
      st_issue: if (cmd_ready) state_next = st_idle;
      st_cpl_wr: if (cpl_ready) state_next = st_idle;
      default: state_next = st_idle;
    endcase
  end

  // RL16 local reset clears only this engine
  always_ff @(posedge clk or posedge reset) begin
    if (reset) state_reg <= st_idle;
    else state_reg <= state_next;
  end

  // word counter and ring choice
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      word_reg <= 4'h0;
      sel_reg <= ADMIN_ID;
    end else begin
      if (state_reg == st_idle) sel_reg <= pick;
      if (state_reg == st_idle || state_reg == st_eval || state_reg == st_emit) word_reg <= 4'h0;
      else if (mem_rsp_valid || (mem_req_write && mem_req_ready)) word_reg <= word_reg + 4'h1;
    end
  end

  // RL4 sixteen words land in the command store
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_words_reg <= '{default: 32'h0};
    end else if (state_reg == st_fetch_wait && mem_rsp_valid) begin
      cmd_words_reg[word_reg] <= mem_rsp_rdata;
    end
  end

  // walk state over inline, list and segment entries
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ent_reg <= '{default: 32'h0};
      ent_addr_reg <= 32'h0;
      ent_left_reg <= 8'h0;
      {sgl_reg, inline_reg, second_reg} <= 3'b000;
    end else if (fetch_done) begin
      for (int i = 0; i < 3; i++) ent_reg[i] <= cmd_words_reg[PTR1_WORD + i];
      ent_reg[3] <= mem_rsp_rdata & 32'h0 | cmd_words_reg[PTR1_WORD + 3];
      sgl_reg <= (dw0[DESC_SEL_HI:DESC_SEL_LO] != 2'h0);
      {inline_reg, second_reg} <= 2'b10;
      ent_left_reg <= 8'h0;
    end else if (state_reg == st_eval && eval_chain) begin
      ent_addr_reg <= ent_reg[0];
      ent_left_reg <= seg_count;
      inline_reg <= 1'b0;
    end else if (step && want_second) begin
      second_reg <= 1'b1;
      ent_reg[0] <= cmd_words_reg[PTR2_WORD];
      if (second_list) begin
        ent_addr_reg <= cmd_words_reg[PTR2_WORD];
        ent_left_reg <= PRP_LIST_MAX;
        inline_reg <= 1'b0;
      end
    end else if (state_reg == st_ent_rd && mem_req_ready) begin
      ent_addr_reg <= ent_addr_reg + 32'h4;
    end else if (state_reg == st_ent_wait && mem_rsp_valid) begin
      ent_reg[word_reg[1:0]] <= mem_rsp_rdata;
      if (ent_done) ent_left_reg <= ent_left_reg - 8'h1;
    end
  end

  // descriptor and command outputs, held through their handshakes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {desc_addr, desc_len} <= 64'h0;
      {cmd_ring, cmd_admin, cmd_id, cmd_opcode} <= 26'h0;
    end else begin
      if (state_reg == st_eval && eval_emit) desc_addr <= ent_reg[0];
      if (state_reg == st_eval && eval_emit) desc_len <= sgl_reg ? ent_reg[2] : 32'h0;
      if (fetch_done) begin
        cmd_ring <= sel_reg;
        // RL17 identifier zero is admin; RL18 the rest are io
        cmd_admin <= (sel_reg == ADMIN_ID);
        cmd_id <= dw0[CID_LO+15:CID_LO];
        cmd_opcode <= dw0[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  fetch_bound_a: assert property (@(posedge clk) disable iff (reset) // RL21
    state_reg == st_fetch |-> !empty[sel_reg]) else $error("fetch past tail");
  cq_room_a: assert property (@(posedge clk) disable iff (reset) // RL20
    $rose(mem_req_write) |-> !full[CQ_IDX]) else $error("completion into unfreed slot");
  head_step_a: assert property (@(posedge clk) disable iff (reset) // RL3
    fetch_done |=> state_reg == st_eval && dev_ptr[sel_reg] != $past(dev_ptr[sel_reg]))
    else $error("head did not step after fetch");
  admin_flag_a: assert property (@(posedge clk) disable iff (reset) // RL17
    cmd_valid |-> cmd_admin == (cmd_ring == ADMIN_ID)) else $error("admin flag mismatch");
  cpl_entry_a: assert property (@(posedge clk) disable iff (reset) // RL8
    cpl_ready |-> mem_req_wdata[15:0] == cpl_id && mem_req_wdata[CPL_PHASE_BIT] == phase[CQ_IDX])
    else $error("completion id or phase wrong");
  cq_step_a: assert property (@(posedge clk) disable iff (reset) // RL9
    cpl_ready |=> state_reg == st_idle ##0 dev_ptr[CQ_IDX] != $past(dev_ptr[CQ_IDX]))
    else $error("completion ring tail did not move");
  desc_hold_a: assert property (@(posedge clk) disable iff (reset) // RL6
    desc_valid && !desc_ready |=> desc_valid && $stable(desc_addr))
    else $error("descriptor dropped before accepted");
  cmd_hold_a: assert property (@(posedge clk) disable iff (reset) // RL15
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_id))
    else $error("command changed before accepted");
  wire_fetch_a: assert property (@(posedge clk) disable iff (reset) // RL4
    fetch_done |-> word_reg == CMD_LAST_WORD ##1 word_reg == 4'h0)
    else $error("command not sixteen words");

endmodule : queue_pair_engine

// ===== ring_pointer.sv
`timescale 1ns/1ps
module ring_pointer (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // host side doorbell
  input wire logic host_load,
  input wire logic [qp_pkg::IDX_W-1:0] host_value,
  // device side progress
  input wire logic dev_advance,
  // pointer state
  output logic [qp_pkg::IDX_W-1:0] host_ptr,
  output logic [qp_pkg::IDX_W-1:0] dev_ptr,
  output wire logic empty,
  output wire logic full,
  output logic phase
);
  import qp_pkg::*;

  logic [IDX_W-1:0] dev_ptr_next;
  wire dev_wrap = (dev_ptr == LAST_SLOT);

  // RL20 wrap to zero
  assign dev_ptr_next = dev_wrap ? '0 : dev_ptr + 3'h1;
  // RL21 equal pointers mean empty
  assign empty = (dev_ptr == host_ptr);
  // RL20 slot not yet freed
  assign full = (dev_ptr_next == host_ptr);

  // RL2 doorbell overwrites pointer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      host_ptr <= '0;
    end else if (host_load) begin
      host_ptr <= host_value;
    end
  end

  // RL11 phase flips per pass
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dev_ptr <= '0;
      phase <= 1'b1;
    end else if (dev_advance) begin
      dev_ptr <= dev_ptr_next;
      phase <= phase ^ dev_wrap;
    end
  end

  doorbell_load_a: assert property (@(posedge clk) disable iff (reset) // RL2
    host_load |=> host_ptr == $past(host_value)) else $error("doorbell value not held");
  ring_wrap_a: assert property (@(posedge clk) disable iff (reset) // RL20
    (dev_advance && dev_ptr == LAST_SLOT) |=> dev_ptr == '0) else $error("ring did not wrap");
  phase_flip_a: assert property (@(posedge clk) disable iff (reset) // RL11
    dev_advance |=> phase == ($past(phase) ^ ($past(dev_ptr) == LAST_SLOT)))
    else $error("phase marker wrong after advance");

endmodule : ring_pointer
